// ===== testbench/amd_checker_asserts.sv
/*
  checker for the address map decoder top module ports.
  assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module amd_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        access_req_in,
  input wire logic [23:0] access_addr_in,
  input wire logic        opcode_valid_in,
  input wire logic [7:0]  opcode_in,
  input wire logic        opcode_implemented_in,
  input wire logic        sel_reg_out,
  input wire logic        sel_cram_out,
  input wire logic        sel_sfr_out,
  input wire logic        sel_ext_out,
  input wire logic        sel_rsv_out,
  input wire logic        rsv_access_flag_out,
  input wire logic        mode_violation_out,
  input wire logic [19:0] external_address_pins_out,
  input wire logic [3:0]  ext_page_out,
  input wire logic [15:0] ext_page_offset_out,
  input wire logic        ext_strobe_out,
  input wire logic        default_chip_select_n_out,
  input wire logic        access_done_out,
  input wire logic        first_fetch_out,
  input wire logic        core_reset_req_out,
  input wire logic        unimpl_opcode_irq_out,
  input wire logic        code_mode_config_bit_out,
  input wire logic        config_loaded_out
);
  logic [19:0] low_addr;
  assign low_addr = access_addr_in[19:0];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_onehot;
    access_req_in |-> $onehot({sel_reg_out, sel_cram_out, sel_sfr_out,
                               sel_ext_out, sel_rsv_out});
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("target select not one-hot");
  property p_pins;
    ext_strobe_out |=> external_address_pins_out == $past(low_addr);
  endproperty
  a_pins: assert property (p_pins)
    else $error("pins do not carry low address bits");
  property p_page;
    ext_page_out == external_address_pins_out[19:16] &&
    ext_page_offset_out == external_address_pins_out[15:0];
  endproperty
  a_page: assert property (p_page)
    else $error("page split wrong");
  property p_rst_op;
    opcode_valid_in && opcode_in == 8'hFF |=> core_reset_req_out;
  endproperty
  a_rst_op: assert property (p_rst_op)
    else $error("all-ones opcode gave no reset");
  property p_irq;
    opcode_valid_in && opcode_in != 8'hFF |=>
      unimpl_opcode_irq_out == !$past(opcode_implemented_in);
  endproperty
  a_irq: assert property (p_irq)
    else $error("unimplemented opcode pulse wrong");
  property p_rsv;
    access_req_in && sel_rsv_out |->
      rsv_access_flag_out && !ext_strobe_out && access_done_out;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved access not refused");
  property p_cram;
    $rose(access_req_in) && sel_cram_out && !mode_violation_out |->
      !access_done_out ##1 !access_done_out ##1 access_done_out;
  endproperty
  a_cram: assert property (p_cram)
    else $error("code ram timing wrong");
  property p_ext;
    $rose(access_req_in) && sel_ext_out && !mode_violation_out |->
      !access_done_out [*3] ##1 access_done_out;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external timing wrong");
  property p_first;
    $rose(rst_n_in) |-> first_fetch_out && !default_chip_select_n_out;
  endproperty
  a_first: assert property (p_first)
    else $error("reset fetch state wrong");
  property p_freeze;
    config_loaded_out && $past(config_loaded_out) |->
      $stable(code_mode_config_bit_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("code mode changed after load");
  property p_viol;
    mode_violation_out |-> access_done_out && !ext_strobe_out;
  endproperty
  a_viol: assert property (p_viol)
    else $error("illegal mode access not refused");
  c_viol: cover property (mode_violation_out);
  c_reset: cover property (core_reset_req_out);
  c_cram: cover property ($rose(access_req_in) && sel_cram_out);
  c_rsv: cover property (rsv_access_flag_out);
endmodule
bind amd_address_map_decoder amd_checker amd_checker_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .access_req_in(access_req_in), .access_addr_in(access_addr_in),
  .opcode_valid_in(opcode_valid_in), .opcode_in(opcode_in),
  .opcode_implemented_in(opcode_implemented_in),
  .sel_reg_out(sel_reg_out), .sel_cram_out(sel_cram_out),
  .sel_sfr_out(sel_sfr_out), .sel_ext_out(sel_ext_out),
  .sel_rsv_out(sel_rsv_out), .rsv_access_flag_out(rsv_access_flag_out),
  .mode_violation_out(mode_violation_out),
  .external_address_pins_out(external_address_pins_out),
  .ext_page_out(ext_page_out), .ext_page_offset_out(ext_page_offset_out),
  .ext_strobe_out(ext_strobe_out),
  .default_chip_select_n_out(default_chip_select_n_out),
  .access_done_out(access_done_out), .first_fetch_out(first_fetch_out),
  .core_reset_req_out(core_reset_req_out),
  .unimpl_opcode_irq_out(unimpl_opcode_irq_out),
  .code_mode_config_bit_out(code_mode_config_bit_out),
  .config_loaded_out(config_loaded_out));
`default_nettype wire

// ===== testbench/amd_ext_mem.sv
/*
  external program memory model on the address pins.
  assumes pins are valid from the cycle after the external strobe goes high.
*/
`timescale 1ns/100ps
`default_nettype none
module amd_ext_mem (
  input  wire logic [19:0] addr_in,
  input  wire logic        strobe_in,
  output logic [7:0]       data_out
);
  // one programmed byte; unprogrammed cells and the idle pulled-up
  // bus read all ones
  always_comb
    if (strobe_in && addr_in == 20'hF_2080)
      data_out = 8'h12;
    else
      data_out = 8'hFF;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
/*
  testbench for the address map decoder: region table, timing, opcodes.
  assumes chip select 0 covers pages 10 to 1f once enabled.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import amd_pkg::*;
  localparam logic [4:0] R = 5'h10, C = 5'h08, S = 5'h04, E = 5'h02;
  localparam logic [4:0] V = 5'h01;
  localparam logic [23:0] AD [19] = '{24'h00_0010, 24'h00_0080,
    24'h00_0150, 24'h00_0300, 24'h00_0400, 24'h00_1C00, 24'h00_1F00,
    24'h00_2000, 24'h00_F000, 24'h00_F800, 24'h00_FFFF, 24'h01_0000,
    24'h0E_FFFF, 24'h0F_0000, 24'hFF_0000, 24'hFF_0400, 24'hFF_2000,
    24'hFF_2080, 24'hFF_F800};
  localparam logic [4:0] TG [19] = '{R, R, R, V, E, V, S, E, E, C, C, E,
    E, V, V, E, E, E, E};
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, fch = 1'b0, dir = 1'b0;
  logic ext = 1'b0, ov = 1'b0, imp = 1'b0, cv = 1'b0;
  logic [23:0] addr = 24'h00_0000;
  logic [7:0] opc = 8'h00, cb = 8'h00, md, rd;
  logic sr, sc, ss, se, sv, done, dcs, ff, rr, irq, mode;
  logic [19:0] pins;
  logic [23:0] ffa;
  logic mv, stb, ldd, win = 1'b0, win2 = 1'b0;
  logic [5:0] csn, cse = 6'h00;
  logic [6:0] xcs = 7'h7E;
  int n_fail = 0, checked = 0, cyc = 0;
  always #25 clk = ~clk;
  amd_address_map_decoder amd_address_map_decoder_i (
    .clk_sys_in(clk), .rst_n_in(rst_n), .access_req_in(req),
    .access_addr_in(addr), .access_fetch_in(fch), .access_direct_in(dir),
    .access_extended_in(ext), .access_window_in(win),
    .access_window2_in(win2), .opcode_valid_in(ov), .opcode_in(opc),
    .opcode_implemented_in(imp), .config_byte_valid_in(cv),
    .config_byte_in(cb), .cs_enable_in(cse),
    .cs_base_in({120'h0, 24'h10_0000}),
    .cs_mask_in({120'h0, 24'hF0_0000}), .sel_reg_out(sr),
    .sel_cram_out(sc), .sel_sfr_out(ss), .sel_ext_out(se),
    .sel_rsv_out(sv), .rsv_access_flag_out(), .mode_violation_out(mv),
    .external_address_pins_out(pins), .ext_page_out(),
    .ext_page_offset_out(), .ext_strobe_out(stb),
    .chip_select_n_out(csn),
    .default_chip_select_n_out(dcs), .access_done_out(done),
    .first_fetch_out(ff), .first_fetch_addr_out(ffa),
    .core_reset_req_out(rr), .unimpl_opcode_irq_out(irq),
    .code_mode_config_bit_out(mode), .config_loaded_out(ldd));
  amd_ext_mem amd_ext_mem_i (.addr_in(pins), .strobe_in(stb),
    .data_out(md));
  task automatic check(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic reset_cfg(input logic [7:0] b);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(24'(ff), 24'h1);
    check(ffa, 24'hFF_2080);
    check(24'(dcs), 24'h0);
    @(negedge clk);
    cv = 1'b1;
    cb = b;
    @(negedge clk);
    cv = 1'b0;
    @(negedge clk);
    check(24'({ff, ldd}), 24'h1);
  endtask
  task automatic acc(input logic [23:0] a, input logic [4:0] et);
    int n;
    n = 0;
    addr = a;
    dir = (a < 24'h00_001A);
    ext = !dir;
    fch = (a[23:16] == 8'hFF);
    req = 1'b1;
    #1;
    check(24'({mv, sr, sc, ss, se, sv}), 24'(et));
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd = md;
    check(24'(n), (et == E) ? 24'h3 : (et == C) ? 24'h2 : 24'h0);
    @(posedge clk);
    @(negedge clk);
    req = 1'b0;
    if (et == E) begin
      check(24'(pins), 24'(a[19:0]));
      check(24'({csn, dcs}), 24'(xcs));
    end
    @(negedge clk);
  endtask
  task automatic bad(input logic [23:0] a, input logic [4:0] f,
                     input logic [2:0] e);
    addr = a;
    {dir, ext, fch, win, win2} = f;
    req = 1'b1;
    #1;
    check(24'({mv, done, stb}), 24'(e));
    @(negedge clk);
    req = 1'b0;
    {win, win2} = 2'b00;
    @(negedge clk);
  endtask
  task automatic op(input logic [7:0] b, input logic i, input logic [1:0] e);
    ov = 1'b1;
    opc = b;
    imp = i;
    @(negedge clk);
    ov = 1'b0;
    check(24'({rr, irq}), 24'(e));
    @(negedge clk);
    check(24'({rr, irq}), 24'h0);
  endtask
  initial begin
    reset_cfg(8'h00);
    check(24'(mode), 24'h0);
    for (int k = 0; k < 19; k++)
      acc(AD[k], TG[k]);
    op(rd, 1'b1, 2'b10);
    acc(24'hFF_2080, E);
    op(rd, 1'b0, 2'b01);
    op(rd, 1'b1, 2'b00);
    reset_cfg(8'h02);
    check(24'(mode), 24'h1);
    cv = 1'b1;
    cb = 8'h00;
    @(negedge clk);
    cv = 1'b0;
    check(24'(mode), 24'h1);
    acc(24'hFF_F800, C);
    acc(24'hFF_FFFF, C);
    acc(24'h00_F800, C);
    bad(24'h00_0010, 5'b01000, 3'b110);
    bad(24'h01_0000, 5'b00000, 3'b110);
    bad(24'h01_0000, 5'b01100, 3'b110);
    bad(24'h00_2000, 5'b01001, 3'b110);
    bad(24'h00_F800, 5'b01010, 3'b110);
    bad(24'h00_1F00, 5'b01010, 3'b010);
    cse = 6'h01;
    xcs = 7'h7D;
    acc(24'h10_2000, E);
    acc(24'h1F_0000, V);
    acc(24'h20_0000, V);
    end_sim;
  end
endmodule
`default_nettype wire

// ===== verilog/amd_address_map_decoder.sv
/*
  address map decoder: steers each core access to a target, drives
  the 20-bit external address, handles reset fetch, opcode traps and
  code mode capture.
  assumes a core that holds access_req_in until access_done_out, and
  that the config byte arrives once after reset on config_byte_valid_in.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amd_params.svh"
module amd_address_map_decoder
  import amd_pkg::*;
#(
  parameter int CS_COUNT = `AMD_CS_COUNT
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic                access_req_in,
  input  wire logic [23:0]         access_addr_in,
  input  wire logic                access_fetch_in,
  input  wire logic                access_direct_in,
  input  wire logic                access_extended_in,
  input  wire logic                access_window_in,
  input  wire logic                access_window2_in,
  input  wire logic                opcode_valid_in,
  input  wire logic [7:0]          opcode_in,
  input  wire logic                opcode_implemented_in,
  input  wire logic                config_byte_valid_in,
  input  wire logic [7:0]          config_byte_in,
  input  wire logic [CS_COUNT-1:0] cs_enable_in,
  input  wire logic [CS_COUNT*24-1:0] cs_base_in,
  input  wire logic [CS_COUNT*24-1:0] cs_mask_in,
  output logic                     sel_reg_out,
  output logic                     sel_cram_out,
  output logic                     sel_sfr_out,
  output logic                     sel_ext_out,
  output logic                     sel_rsv_out,
  output logic                     rsv_access_flag_out,
  output logic                     mode_violation_out,
  output logic [19:0]              external_address_pins_out,
  output logic [3:0]               ext_page_out,
  output logic [15:0]              ext_page_offset_out,
  output logic                     ext_strobe_out,
  output logic                     default_chip_select_n_out,
  output logic [CS_COUNT-1:0]      chip_select_n_out,
  output logic                     access_done_out,
  output logic                     first_fetch_out,
  output logic [23:0]              first_fetch_addr_out,
  output logic                     core_reset_req_out,
  output logic                     unimpl_opcode_irq_out,
  output logic                     code_mode_config_bit_out,
  output logic                     config_loaded_out
);
  amd_target_t tgt;
  amd_target_t tgt_eff;
  logic        overlay_page;
  logic        ice_slot;
  logic        core_direct_only;
  logic        window2_ok;
  logic        window_any_ok;
  logic        code_fetch_ok;
  logic        illegal_mode;
  logic        violation;
  amd_state_t  state_reg;
  logic        code_mode_reg;
  logic [1:0]  wait_reg;
  logic [1:0]  wait_next;
  logic        busy_reg;
  logic [CS_COUNT-1:0] cs_hit;

  amd_region_decode u_region (
    .addr_in                 (access_addr_in),
    .code_mode_config_bit_in (code_mode_reg),
    .target_out              (tgt),
    .core_direct_only_out    (core_direct_only),
    .window2_ok_out          (window2_ok),
    .window_any_ok_out       (window_any_ok),
    .code_fetch_ok_out       (code_fetch_ok)
  );

  // post-reset sequence: fetch config then run
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg <= AMD_ST_RESET;
    end else begin
      case (state_reg)
        AMD_ST_RESET: state_reg <= AMD_ST_CFG;
        AMD_ST_CFG: begin
          if (config_byte_valid_in)
            state_reg <= AMD_ST_RUN;
        end
        AMD_ST_RUN: state_reg <= AMD_ST_RUN;
        default: state_reg <= AMD_ST_RESET;
      endcase
    end
  end

  // code mode captured once, frozen until reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in)
      code_mode_reg <= 1'b0;
    else if (state_reg == AMD_ST_CFG && config_byte_valid_in)
      code_mode_reg <= config_byte_in[1];
  end

  assign code_mode_config_bit_out = code_mode_reg;
  assign config_loaded_out = (state_reg == AMD_ST_RUN);

  // overlay pages reach the bus only through a programmed chip select
  assign overlay_page = (access_addr_in[23:16] > `AMD_EXTP_HI) &&
                        (access_addr_in[23:16] != `AMD_PAGE_FF);
  assign ice_slot = (access_addr_in[19:16] == 4'hF) &&
                    (access_addr_in[15:0] <= `AMD_ICE_HI);
  assign tgt_eff = (tgt == AMD_TGT_RSV && overlay_page && !ice_slot &&
                    (|cs_hit)) ? AMD_TGT_EXT : tgt;

  // one-hot target selects
  assign sel_reg_out  = (tgt_eff == AMD_TGT_REG);
  assign sel_cram_out = (tgt_eff == AMD_TGT_CRAM);
  assign sel_sfr_out  = (tgt_eff == AMD_TGT_SFR);
  assign sel_ext_out  = (tgt_eff == AMD_TGT_EXT);
  assign sel_rsv_out  = (tgt_eff == AMD_TGT_RSV);

  // addressing mode checks against the region
  always_comb begin
    illegal_mode = 1'b0;
    if (core_direct_only && !access_direct_in)
      illegal_mode = 1'b1;
    if (access_window2_in && !window2_ok)
      illegal_mode = 1'b1;
    if (access_window_in && !window_any_ok)
      illegal_mode = 1'b1;
    if (access_addr_in[23:16] != `AMD_PAGE_00 && !access_extended_in &&
        !access_fetch_in)
      illegal_mode = 1'b1;
    if (access_fetch_in && !code_fetch_ok)
      illegal_mode = 1'b1;
  end

  assign violation = illegal_mode || sel_rsv_out;
  assign rsv_access_flag_out = access_req_in && sel_rsv_out;
  assign mode_violation_out  = access_req_in && illegal_mode;

  // access latency per target
  always_comb begin
    case (tgt_eff)
      AMD_TGT_CRAM: wait_next = `AMD_WAIT_CRAM;
      AMD_TGT_EXT:  wait_next = `AMD_WAIT_EXT;
      default:      wait_next = `AMD_WAIT_REG;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else if (!busy_reg) begin
      if (access_req_in && !access_done_out) begin
        busy_reg <= (wait_next != `AMD_WAIT_REG);
        wait_reg <= wait_next;
      end
    end else if (wait_reg == 2'h1) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg - 2'h1;
    end
  end

  assign access_done_out = access_req_in &&
    ((!busy_reg && (wait_next == `AMD_WAIT_REG || violation)) ||
     (busy_reg && wait_reg == 2'h1));

  // only external, legal accesses reach the bus
  assign ext_strobe_out = access_req_in && sel_ext_out && !illegal_mode &&
                          (state_reg != AMD_ST_RESET);

  // low 20 bits out; upper nibble dropped so pages alias
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      external_address_pins_out <= 20'h0_0000;
    end else if (ext_strobe_out) begin
      external_address_pins_out <=
        access_addr_in[`AMD_EXT_ADDR_W-1:0];
    end
  end

  assign ext_page_out        = external_address_pins_out[19:16];
  assign ext_page_offset_out = external_address_pins_out[15:0];

  // full 24-bit chip select compare per output
  generate
    for (genvar i = 0; i < CS_COUNT; i++) begin : g_cs
      assign cs_hit[i] = cs_enable_in[i] &&
        (((access_addr_in ^ cs_base_in[i*24 +: 24]) &
          cs_mask_in[i*24 +: 24]) == 24'h00_0000);
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in)
      chip_select_n_out <= {CS_COUNT{1'b1}};
    else if (ext_strobe_out)
      chip_select_n_out <= ~cs_hit;
    else if (!access_req_in)
      chip_select_n_out <= {CS_COUNT{1'b1}};
  end

  // default chip select active out of reset; once config loads, each external access leaves it active only when no chip select hits
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in)
      default_chip_select_n_out <= 1'b0;
    else if (state_reg == AMD_ST_RUN && ext_strobe_out)
      default_chip_select_n_out <= ~(cs_hit == '0);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in)
      first_fetch_out <= 1'b1;
    else if (state_reg == AMD_ST_RUN)
      first_fetch_out <= 1'b0;
  end

  assign first_fetch_addr_out = `AMD_RESET_FETCH_ADDR;

  // opcode traps
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      core_reset_req_out    <= 1'b0;
      unimpl_opcode_irq_out <= 1'b0;
    end else begin
      core_reset_req_out <= opcode_valid_in &&
        (opcode_in == `AMD_RST_OPCODE);
      unimpl_opcode_irq_out <= opcode_valid_in &&
        (opcode_in != `AMD_RST_OPCODE) &&
        !opcode_implemented_in;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/amd_params.svh
/*
  address map decoder constants: range bounds, reset fetch address,
  access timing and opcode values.
  assumes inclusion by bare name from the modules.
*/
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

`define AMD_RESET_FETCH_ADDR  24'hFF_2080
`define AMD_RST_OPCODE        8'hFF
`define AMD_EXT_ADDR_W        20
`define AMD_PAGE_FF           8'hFF
`define AMD_PAGE_00           8'h00
`define AMD_MIRROR_LO         16'hF800
`define AMD_ICE_LO            16'h0000
`define AMD_ICE_HI            16'h03FF
`define AMD_PROG_LO           16'h2080
`define AMD_SPM_LO            16'h2000
`define AMD_CORE_HI           24'h00_0019
`define AMD_LREG_HI           24'h00_00FF
`define AMD_UREG_HI           24'h00_01FF
`define AMD_RSVREG_HI         24'h00_03FF
`define AMD_EXTA_HI           24'h00_1BFF
`define AMD_RSVSFR_HI         24'h00_1EFF
`define AMD_SFR_HI            24'h00_1FFF
`define AMD_EXTB_HI           24'h00_EFFF
`define AMD_EXTW_HI           24'h00_F7FF
`define AMD_CRAM_HI           24'h00_FFFF
`define AMD_EXTP_LO           8'h01
`define AMD_EXTP_HI           8'h0E
`define AMD_WAIT_REG          2'h0
`define AMD_WAIT_CRAM         2'h2
`define AMD_WAIT_EXT          2'h3
`define AMD_CS_COUNT          6

`endif

// ===== verilog/amd_pkg.sv
/*
  address map decoder types.
  assumes amd_params.svh is on the include path.
*/
`default_nettype none
package amd_pkg;
  typedef enum logic [2:0] {
    AMD_TGT_REG,
    AMD_TGT_CRAM,
    AMD_TGT_SFR,
    AMD_TGT_EXT,
    AMD_TGT_RSV
  } amd_target_t;

  typedef enum {
    AMD_ST_RESET,
    AMD_ST_CFG,
    AMD_ST_RUN
  } amd_state_t;
endpackage
`default_nettype wire

// ===== verilog/amd_region_decode.sv
/*
  combinational region decode of a 24-bit internal address.
  assumes the code mode bit is stable while an access is decoded.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amd_params.svh"
module amd_region_decode
  import amd_pkg::*;
(
  input  wire logic [23:0] addr_in,
  input  wire logic        code_mode_config_bit_in,
  output amd_target_t      target_out,
  output logic             core_direct_only_out,
  output logic             window2_ok_out,
  output logic             window_any_ok_out,
  output logic             code_fetch_ok_out
);
  logic [7:0]  page;
  logic [15:0] offs;

  assign page = addr_in[23:16];
  assign offs = addr_in[15:0];

  always_comb begin
    target_out = AMD_TGT_RSV;
    if (page == `AMD_PAGE_00) begin
      if (addr_in <= `AMD_CORE_HI)
        target_out = AMD_TGT_REG;
      else if (addr_in <= `AMD_LREG_HI)
        target_out = AMD_TGT_REG;
      else if (addr_in <= `AMD_UREG_HI)
        target_out = AMD_TGT_REG;
      else if (addr_in <= `AMD_RSVREG_HI)
        target_out = AMD_TGT_RSV;
      else if (addr_in <= `AMD_EXTA_HI)
        target_out = AMD_TGT_EXT;
      else if (addr_in <= `AMD_RSVSFR_HI)
        target_out = AMD_TGT_RSV;
      else if (addr_in <= `AMD_SFR_HI)
        target_out = AMD_TGT_SFR;
      else if (addr_in <= `AMD_EXTB_HI)
        target_out = AMD_TGT_EXT;
      else if (addr_in <= `AMD_EXTW_HI)
        target_out = AMD_TGT_EXT;
      else
        target_out = AMD_TGT_CRAM;
    end else if (page >= `AMD_EXTP_LO && page <= `AMD_EXTP_HI) begin
      if (offs <= `AMD_ICE_HI && page[3:0] == 4'hF)
        target_out = AMD_TGT_RSV;
      else
        target_out = AMD_TGT_EXT;
    end else if (page == `AMD_PAGE_FF) begin
      if (offs <= `AMD_ICE_HI)
        target_out = AMD_TGT_RSV;
      else if (offs >= `AMD_MIRROR_LO)
        target_out = code_mode_config_bit_in ? AMD_TGT_CRAM
                                             : AMD_TGT_EXT;
      else
        target_out = AMD_TGT_EXT;
    end else begin
      target_out = AMD_TGT_RSV;
    end
  end

  assign core_direct_only_out = (addr_in <= `AMD_CORE_HI);
  assign window2_ok_out = (page == `AMD_PAGE_00) &&
    ((addr_in > `AMD_EXTB_HI) ||
     (addr_in > `AMD_RSVSFR_HI && addr_in <= `AMD_SFR_HI) ||
     (addr_in > `AMD_LREG_HI && addr_in <= `AMD_UREG_HI));
  assign window_any_ok_out = (page == `AMD_PAGE_00) &&
    ((addr_in > `AMD_RSVSFR_HI && addr_in <= `AMD_SFR_HI) ||
     (addr_in > `AMD_LREG_HI && addr_in <= `AMD_UREG_HI));
  // 64k mode: fetch only from page ff
  assign code_fetch_ok_out = code_mode_config_bit_in ?
    (page == `AMD_PAGE_FF) : 1'b1;
endmodule
`default_nettype wire
